// ### hw/dlcr_pkg.sv
// Constants for the per-slot Layer 1 channel router of one serial port.
// Assumes one system clock; slot timing and byte sources sit outside.
// Operation
// - Keep last received byte, low half
// - Keep last transmitted byte, high half
// - Channel code k means channel k+1
// - Unchannelized uses entry 0 for channel, enable
// - Receive seven-bit mode drops LSB
// - Loop search sees all eight bits
// - Loop search when enabled or unchannelized
// - Local loopback needs enable, 64k
// - Receive tester route, LSB dropped
// - Disabled slot still feeds search, tester
// - Transmit seven-bit mode forces LSB one
// - Force-ones beats transmit enable
// - Network loopback beats everything
// - Tester source beats force-ones, enable
// - Disabled slot still carries tester data
// - Table select 00/01/10, 11 illegal
// - Busy flag set until access done
package dlcr_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int SLOTS = 128;
	localparam int SLOT_W = 7;

	// ------------------------------------------------------------
	// Indirect select register fields
	// ------------------------------------------------------------
	localparam int SEL_SLOT_LSB = 0;
	localparam int SEL_TBL_LSB = 8;
	localparam int SEL_DIR_BIT = 14;
	localparam int SEL_BUSY_BIT = 15;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Table select codes
	localparam logic [1:0] TBL_LOOP = 2'h0;
	localparam logic [1:0] TBL_RX = 2'h1;
	localparam logic [1:0] TBL_TX = 2'h2;

	// ------------------------------------------------------------
	// Configuration entry fields
	// ------------------------------------------------------------
	localparam int CFG_SEVEN_BIT = 8;
	localparam int CFG_FORCE_ONES_BIT = 9;
	localparam int CFG_LOCAL_LB_BIT = 10;
	localparam int CFG_NET_LB_BIT = 11;
	localparam int CFG_SEARCH_BIT = 12;
	localparam int CFG_TESTER_BIT = 14;
	localparam int CFG_ENABLE_BIT = 15;

	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] LSB_CLEAR = 8'hFE;
	localparam logic [7:0] LSB_SET = 8'h01;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_BUSY = 2'b01
	} dlcr_acc_e;

endpackage

// ### hw/dlcr_router.sv
// Per-slot receive/transmit router with loopback data store and
// indirect host access. Slot strobes and byte sources are on sys_clk.
// Receive outputs follow a slot strobe by one cycle; transmit
// requests follow by one cycle and the line byte by two.
module dlcr_router
	import dlcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	// Host indirect registers
	input wire logic sel_we,
	input wire logic data_we,
	input wire logic [15:0] host_wdata,
	output logic [15:0] sel_rdata,
	output logic [15:0] indirect_data_reg,
	output logic indirect_busy,
	// Port mode
	input wire logic rx_unchannelized,
	input wire logic tx_unchannelized,
	// Receive slot stream
	input wire logic rx_slot_valid,
	input wire logic [6:0] rx_slot_num,
	input wire logic [7:0] rx_byte,
	output logic rx_hdlc_valid,
	output logic [7:0] rx_hdlc_channel_sel,
	output logic [7:0] rx_hdlc_data,
	output logic rx_hdlc_seven,
	output logic rx_tester_valid,
	output logic [7:0] rx_tester_data,
	output logic rx_tester_seven,
	output logic rx_search_valid,
	output logic [7:0] rx_search_data,
	// Transmit slot stream
	input wire logic tx_slot_valid,
	input wire logic [6:0] tx_slot_num,
	output logic tx_hdlc_req,
	output logic [7:0] tx_hdlc_channel_sel,
	input wire logic [7:0] tx_hdlc_byte,
	output logic tx_tester_req,
	input wire logic [7:0] tx_tester_byte,
	output logic serial_tx_valid,
	output logic [7:0] serial_tx_line
);

	// ------------------------------------------------------------
	// Tables
	// ------------------------------------------------------------
	// No reset: the host loads every slot before it is used
	logic [7:0] rx_last [SLOTS];
	logic [7:0] tx_last [SLOTS];
	logic [15:0] rx_cfg [SLOTS];
	logic [15:0] tx_cfg [SLOTS];

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Seven-bit shaping; transmit pads LSB with one, receive clears it
	function automatic logic [7:0] shape(input logic [7:0] b, input logic seven, input logic pad);
		logic [7:0] r;
		r = b;
		if (seven) begin
			r = pad ? (b | LSB_SET) : (b & LSB_CLEAR);
		end
		return r;
	endfunction

	function automatic logic [7:0] pick_chan(input logic unch, input logic [15:0] cfg, input logic [15:0] cfg0);
		logic [7:0] c;
		c = unch ? cfg0[7:0] : cfg[7:0];
		return c;
	endfunction

	function automatic logic pick_enable(input logic unch, input logic [15:0] cfg, input logic [15:0] cfg0);
		logic e;
		e = unch ? cfg0[CFG_ENABLE_BIT] : cfg[CFG_ENABLE_BIT];
		return e;
	endfunction

	// Seven-bit mode only counts on a channelized port
	function automatic logic pick_seven(input logic unch, input logic [15:0] cfg);
		logic s;
		s = !unch && cfg[CFG_SEVEN_BIT];
		return s;
	endfunction

	// ------------------------------------------------------------
	// Host indirect access
	// ------------------------------------------------------------
	// One access at a time; strobes are dropped while busy
	dlcr_acc_e acc_state, next_acc_state;
	logic [15:0] sel_reg, next_sel_reg;
	logic [15:0] data_reg, next_data_reg;
	logic host_do, host_rd, host_conflict;
	logic [6:0] host_slot;
	logic [1:0] host_tbl;
	logic rx_store, tx_store;
	logic [6:0] tx_slot_s2;

	assign host_slot = sel_reg[SEL_SLOT_LSB +: SLOT_W];
	assign host_tbl = sel_reg[SEL_TBL_LSB +: 2];
	assign host_rd = sel_reg[SEL_DIR_BIT];
	// Device updates of the loop data win; host waits a cycle
	assign host_conflict = (host_tbl == TBL_LOOP) && !host_rd &&
		((rx_store && rx_slot_num == host_slot) || (tx_store && tx_slot_s2 == host_slot));
	// Only loop-table writes stall; reads and config writes go at once
	assign host_do = (acc_state == ACC_BUSY) && !host_conflict;

	always_comb begin
		next_acc_state = acc_state;
		next_sel_reg = sel_reg;
		next_data_reg = data_reg;
		unique case (acc_state)
			ACC_IDLE: begin
				if (sel_we) begin
					next_sel_reg = host_wdata;
					next_sel_reg[SEL_BUSY_BIT] = 1'b1;
					next_acc_state = ACC_BUSY;
				end else if (data_we) begin
					// Operand loads only while idle
					next_data_reg = host_wdata;
				end
			end
			ACC_BUSY: begin
				if (host_do) begin
					next_sel_reg[SEL_BUSY_BIT] = 1'b0;
					next_acc_state = ACC_IDLE;
					if (host_rd) begin
						unique case (host_tbl)
							TBL_LOOP: next_data_reg = {tx_last[host_slot], rx_last[host_slot]};
							TBL_RX: next_data_reg = rx_cfg[host_slot];
							TBL_TX: next_data_reg = tx_cfg[host_slot];
							default: next_data_reg = DATA_RESET;
						endcase
					end
				end
			end
			default: begin
				// Unused state code: fall back to idle
				next_sel_reg[SEL_BUSY_BIT] = 1'b0;
				next_acc_state = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_state <= ACC_IDLE;
			sel_reg <= SEL_RESET;
			data_reg <= DATA_RESET;
		end else begin
			acc_state <= next_acc_state;
			sel_reg <= next_sel_reg;
			data_reg <= next_data_reg;
		end
	end

	assign sel_rdata = sel_reg;
	assign indirect_data_reg = data_reg;
	assign indirect_busy = sel_reg[SEL_BUSY_BIT];

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------
	logic [15:0] rcfg, rcfg0;
	logic r_en, r_seven, r_lb, r_tester, r_search;
	logic [7:0] r_chan, r_src;
	logic next_rx_hdlc_valid, next_rx_tester_valid, next_rx_search_valid;
	logic [7:0] next_rx_hdlc_data, next_rx_tester_data;

	// Every received slot refreshes its loop byte, enabled or not
	assign rx_store = rx_slot_valid;

	always_comb begin
		rcfg = rx_cfg[rx_slot_num];
		rcfg0 = rx_cfg[0];
		r_chan = pick_chan(rx_unchannelized, rcfg, rcfg0);
		r_en = pick_enable(rx_unchannelized, rcfg, rcfg0);
		r_seven = pick_seven(rx_unchannelized, rcfg);
		r_lb = rcfg[CFG_LOCAL_LB_BIT] && r_en && !r_seven;
		// Looped byte feeds engine and tester alike
		r_src = r_lb ? tx_last[rx_slot_num] : rx_byte;
		r_tester = rcfg[CFG_TESTER_BIT];
		// search gate; whole port when unchannelized
		r_search = rx_unchannelized || rcfg[CFG_SEARCH_BIT];
		next_rx_hdlc_valid = rx_slot_valid && r_en;
		next_rx_hdlc_data = shape(r_src, r_seven, 1'b0);
		// tester gets slot data, LSB dropped in 56k
		next_rx_tester_valid = rx_slot_valid && r_tester;
		next_rx_tester_data = shape(r_src, r_seven, 1'b0);
		next_rx_search_valid = rx_slot_valid && r_search;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_hdlc_valid <= 1'b0;
			rx_hdlc_channel_sel <= 8'h00;
			rx_hdlc_data <= 8'h00;
			rx_hdlc_seven <= 1'b0;
			rx_tester_valid <= 1'b0;
			rx_tester_data <= 8'h00;
			rx_tester_seven <= 1'b0;
			rx_search_valid <= 1'b0;
			rx_search_data <= 8'h00;
		end else begin
			// All receive outputs move together
			rx_hdlc_valid <= next_rx_hdlc_valid;
			rx_hdlc_channel_sel <= r_chan;
			rx_hdlc_data <= next_rx_hdlc_data;
			rx_hdlc_seven <= r_seven;
			rx_tester_valid <= next_rx_tester_valid;
			rx_tester_data <= next_rx_tester_data;
			rx_tester_seven <= r_seven;
			rx_search_valid <= next_rx_search_valid;
			rx_search_data <= rx_byte;
		end
	end

	// ------------------------------------------------------------
	// Transmit path: stage 1 config, stage 2 byte
	// ------------------------------------------------------------
	logic t_valid, next_t_valid;
	logic [15:0] tcfg_s, next_tcfg_s;
	logic [6:0] next_tx_slot_s2;
	logic [15:0] tcfg0;
	logic t_en, t_seven, t_nlb, t_tester, t_ones;
	logic [7:0] next_tx_byte;
	logic next_serial_tx_valid;
	logic [7:0] next_tx_hdlc_channel_sel, next_serial_tx_line;

	always_comb begin
		next_t_valid = tx_slot_valid;
		next_tcfg_s = tx_cfg[tx_slot_num];
		next_tx_slot_s2 = tx_slot_num;
		tcfg0 = tx_cfg[0];
		t_en = pick_enable(tx_unchannelized, tcfg_s, tcfg0);
		t_seven = pick_seven(tx_unchannelized, tcfg_s);
		t_nlb = tcfg_s[CFG_NET_LB_BIT];
		t_tester = tcfg_s[CFG_TESTER_BIT];
		t_ones = tcfg_s[CFG_FORCE_ONES_BIT];
		// Loopback, tester, force-ones, enable, idle: first match wins
		// network loopback first
		if (t_nlb) begin
			next_tx_byte = rx_last[tx_slot_s2];
		// tester source over force-ones and enable
		end else if (t_tester) begin
			next_tx_byte = shape(tx_tester_byte, t_seven, 1'b1);
		end else if (t_ones) begin
			next_tx_byte = ALL_ONES;
		end else if (t_en) begin
			next_tx_byte = shape(tx_hdlc_byte, t_seven, 1'b1);
		end else begin
			next_tx_byte = ALL_ONES;
		end
		next_tx_hdlc_channel_sel = pick_chan(tx_unchannelized, next_tcfg_s, tcfg0);
		next_serial_tx_valid = t_valid;
		// Line keeps its last byte between slots
		next_serial_tx_line = t_valid ? next_tx_byte : serial_tx_line;
	end

	// Stored byte is exactly what the line carried
	assign tx_store = t_valid;
	// Requests are combinational so sources answer in the same cycle
	assign tx_hdlc_req = t_valid && t_en && !t_nlb && !t_tester && !t_ones;
	assign tx_tester_req = t_valid && t_tester && !t_nlb;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			t_valid <= 1'b0;
			tcfg_s <= 16'h0000;
			tx_slot_s2 <= 7'h00;
			tx_hdlc_channel_sel <= 8'h00;
			serial_tx_valid <= 1'b0;
			serial_tx_line <= ALL_ONES;
		end else begin
			t_valid <= next_t_valid;
			tcfg_s <= next_tcfg_s;
			tx_slot_s2 <= next_tx_slot_s2;
			tx_hdlc_channel_sel <= next_tx_hdlc_channel_sel;
			serial_tx_valid <= next_serial_tx_valid;
			serial_tx_line <= next_serial_tx_line;
		end
	end

	// ------------------------------------------------------------
	// Table write decode
	// ------------------------------------------------------------
	logic host_wr, loop_wr, rx_cfg_wr, tx_cfg_wr;

	always_comb begin
		host_wr = host_do && !host_rd;
		loop_wr = 1'b0;
		rx_cfg_wr = 1'b0;
		tx_cfg_wr = 1'b0;
		// write to selected table; 11 ignored
		unique case (host_tbl)
			TBL_LOOP: loop_wr = host_wr;
			TBL_RX: rx_cfg_wr = host_wr;
			TBL_TX: tx_cfg_wr = host_wr;
			default: ;
		endcase
	end

	// ------------------------------------------------------------
	// Table writes (memory, no reset)
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rx_store) begin
			rx_last[rx_slot_num] <= rx_byte;
		end
		if (tx_store) begin
			tx_last[tx_slot_s2] <= next_tx_byte;
		end
		// Host loop writes never meet a device update of the same slot
		if (loop_wr) begin
			rx_last[host_slot] <= data_reg[7:0];
			tx_last[host_slot] <= data_reg[15:8];
		end
		if (rx_cfg_wr) begin
			rx_cfg[host_slot] <= data_reg;
		end
		if (tx_cfg_wr) begin
			tx_cfg[host_slot] <= data_reg;
		end
	end

endmodule // dlcr_router

// ### verification/dlcr_router_sva.sv
// Port checker for the slot router.
// Assumes one clock and a synchronous reset.
module dlcr_router_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sel_we,
	input wire logic indirect_busy,
	input wire logic rx_slot_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_hdlc_valid,
	input wire logic [7:0] rx_hdlc_data,
	input wire logic rx_hdlc_seven,
	input wire logic rx_tester_valid,
	input wire logic rx_search_valid,
	input wire logic [7:0] rx_search_data,
	input wire logic tx_slot_valid,
	input wire logic tx_hdlc_req,
	input wire logic tx_tester_req,
	input wire logic [7:0] tx_tester_byte,
	input wire logic serial_tx_valid,
	input wire logic [7:0] serial_tx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----
	// Checks
	// ----
	chk_busy_set: assert property (sel_we && !indirect_busy |=> indirect_busy)
		else $error("busy not raised");
	chk_busy_ends: assert property ($rose(indirect_busy) |-> ##[1:6] !indirect_busy)
		else $error("busy stuck");
	chk_tx_answer: assert property (tx_slot_valid |-> ##2 serial_tx_valid)
		else $error("slot not sent");
	chk_tx_cause: assert property (serial_tx_valid |-> $past(tx_slot_valid, 2))
		else $error("byte without slot");
	chk_one_source: assert property (!(tx_hdlc_req && tx_tester_req))
		else $error("two sources");
	chk_tester_out: assert property (tx_tester_req |=> serial_tx_line[7:1] == $past(tx_tester_byte[7:1]))
		else $error("tester byte lost");
	chk_rx_drop_lsb: assert property (rx_hdlc_valid && rx_hdlc_seven |-> !rx_hdlc_data[0])
		else $error("lsb kept");
	chk_search_raw: assert property (rx_search_valid |-> rx_search_data == $past(rx_byte))
		else $error("search byte changed");
	chk_rx_cause: assert property (rx_hdlc_valid || rx_tester_valid |-> $past(rx_slot_valid))
		else $error("rx output without slot");
	cover property (tx_tester_req);
	cover property (rx_hdlc_valid && rx_hdlc_seven);
	cover property ($fell(indirect_busy));
endmodule // dlcr_router_chk

bind dlcr_router dlcr_router_chk u_chk (.sys_clk(sys_clk), .rst(rst), .sel_we(sel_we),
	.indirect_busy(indirect_busy), .rx_slot_valid(rx_slot_valid), .rx_byte(rx_byte),
	.rx_hdlc_valid(rx_hdlc_valid), .rx_hdlc_data(rx_hdlc_data), .rx_hdlc_seven(rx_hdlc_seven),
	.rx_tester_valid(rx_tester_valid), .rx_search_valid(rx_search_valid), .rx_search_data(rx_search_data),
	.tx_slot_valid(tx_slot_valid), .tx_hdlc_req(tx_hdlc_req), .tx_tester_req(tx_tester_req),
	.tx_tester_byte(tx_tester_byte), .serial_tx_valid(serial_tx_valid), .serial_tx_line(serial_tx_line));

// ### verification/dlcr_partner.sv
// Far-side byte sources: HDLC engine and tester.
// Answers within the request cycle; lines wander outside it.
module dlcr_partner (
	input wire logic sys_clk,
	input wire logic tx_hdlc_req,
	input wire logic [7:0] tx_hdlc_channel_sel,
	input wire logic tx_tester_req,
	output logic [7:0] tx_hdlc_byte,
	output logic [7:0] tx_tester_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;
	always @(posedge sys_clk) cnt <= cnt + 8'h01;
	// Byte tied to channel so a wrong channel shows
	assign tx_hdlc_byte = tx_hdlc_req ? tx_hdlc_channel_sel ^ 8'h5A : cnt;
	assign tx_tester_byte = tx_tester_req ? 8'hC2 : ~cnt;
endmodule // dlcr_partner

// ### verification/test_dlcr_router.sv
// Self-checking bench for the slot router.
// Host, receive and transmit slots driven on sys_clk.
module test_dlcr_router import dlcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, rst = 1'b1, sel_we = 1'b0, data_we = 1'b0, unch = 1'b0, rx_v = 1'b0, tx_v = 1'b0;
	logic [15:0] wd = 16'h0000, r;
	logic [6:0] rx_n = 7'h00, tx_n = 7'h00;
	logic [7:0] rx_b = 8'h00, b;
	wire logic [15:0] sel_rdata, idr;
	wire logic busy, hv, tv, sv, hreq, treq, hs, ts;
	wire logic [7:0] hch, hd, td, tch, hb, tb, line;
	int failures = 0, checks = 0;
	logic [23:0] txr [7] = '{24'h80104A, 24'h81104B, 24'h8210FF, 24'hC210C2, 24'h4110C3, 24'hCA1096, 24'h0010FF};
	logic [35:0] rxr [4] = '{36'h80FF8A500, 36'h81FF8A400, 36'hD1FFEA4A4, 36'h5003600A5};
	dlcr_router u_dut (.sys_clk(sys_clk), .rst(rst), .sel_we(sel_we), .data_we(data_we), .host_wdata(wd),
		.sel_rdata(sel_rdata), .indirect_data_reg(idr), .indirect_busy(busy), .rx_unchannelized(unch),
		.tx_unchannelized(unch), .rx_slot_valid(rx_v), .rx_slot_num(rx_n), .rx_byte(rx_b), .rx_hdlc_valid(hv),
		.rx_hdlc_channel_sel(hch), .rx_hdlc_data(hd), .rx_hdlc_seven(hs), .rx_tester_valid(tv), .rx_tester_data(td),
		.rx_tester_seven(ts), .rx_search_valid(sv), .rx_search_data(), .tx_slot_valid(tx_v), .tx_slot_num(tx_n),
		.tx_hdlc_req(hreq), .tx_hdlc_channel_sel(tch), .tx_hdlc_byte(hb), .tx_tester_req(treq),
		.tx_tester_byte(tb), .serial_tx_valid(), .serial_tx_line(line));
	dlcr_partner u_far (.sys_clk(sys_clk), .tx_hdlc_req(hreq), .tx_hdlc_channel_sel(tch),
		.tx_tester_req(treq), .tx_hdlc_byte(hb), .tx_tester_byte(tb));
	initial forever #5 sys_clk = ~sys_clk;
	// ----
	// Tasks
	// ----
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Write loads the data register first, then the select
	task automatic acc(input logic rd, input logic [1:0] t, input logic [6:0] s, input logic [15:0] d);
		@(posedge sys_clk) data_we <= !rd;
		wd <= d;
		@(posedge sys_clk) data_we <= 1'b0;
		sel_we <= 1'b1;
		wd <= {1'b0, rd, 4'h0, t, 1'b0, s};
		@(posedge sys_clk) sel_we <= 1'b0;
		repeat (8) begin
			@(posedge sys_clk) #1;
			if (!busy) break;
		end
		r = idr;
	endtask
	task automatic rx(input logic [6:0] s, input logic [7:0] v);
		@(posedge sys_clk) rx_v <= 1'b1;
		rx_n <= s;
		rx_b <= v;
		@(posedge sys_clk) rx_v <= 1'b0;
		#1;
	endtask
	task automatic tx(input logic [6:0] s);
		@(posedge sys_clk) tx_v <= 1'b1;
		tx_n <= s;
		@(posedge sys_clk) tx_v <= 1'b0;
		@(posedge sys_clk) #1 b = line;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		give_verdict;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk) #1;
		chk("regs", 32'h0000_0000, {sel_rdata, idr});
		chk("line", 32'h0000_00FF, {busy, line});
		acc(1'b0, TBL_RX, 7'h05, 16'h0010);
		rx(7'h05, 8'h96);
		foreach (txr[i]) begin
			acc(1'b0, TBL_TX, 7'h05, txr[i][23:8]);
			tx(7'h05);
			chk("tx", txr[i][7:0], b);
		end
		acc(1'b1, TBL_LOOP, 7'h05, 16'h0000);
		chk("loop", 16'hFF96, r);
		foreach (rxr[i]) begin
			acc(1'b0, TBL_RX, 7'h03, rxr[i][35:20]);
			rx(7'h03, 8'hA5);
			chk("rx", {rxr[i][19:17], rxr[i][19] ? rxr[i][27:20] : 8'h00, rxr[i][15:0]},
				{hv, tv, sv, hv ? hch : 8'h00, hv ? hd : 8'h00, tv ? td : 8'h00});
			chk("seven", {rxr[i][28], rxr[i][28]}, {hs, ts});
		end
		acc(1'b1, TBL_RX, 7'h03, 16'h0000);
		chk("cfg", 16'h5003, r);
		chk("sel", 16'h4103, sel_rdata);
		acc(1'b1, 2'h3, 7'h03, 16'h0000);
		chk("bad", 16'h0000, r);
		acc(1'b0, TBL_TX, 7'h03, 16'hC210);
		tx(7'h03);
		acc(1'b0, TBL_RX, 7'h03, 16'h8403);
		rx(7'h03, 8'h11);
		chk("llb", 8'hC2, hd);
		acc(1'b0, TBL_RX, 7'h03, 16'h8503);
		rx(7'h03, 8'h11);
		chk("llb56", 8'h10, hd);
		acc(1'b0, TBL_RX, 7'h09, 16'h0010);
		acc(1'b0, TBL_TX, 7'h09, 16'h0010);
		acc(1'b0, TBL_RX, 7'h00, 16'h8077);
		acc(1'b0, TBL_TX, 7'h00, 16'h8033);
		@(posedge sys_clk) unch <= 1'b1;
		rx(7'h09, 8'h3C);
		chk("unch", {1'b1, 8'h77, 1'b1}, {hv, hch, sv});
		tx(7'h09);
		chk("untx", 8'h69, b);
		give_verdict;
	end
endmodule // test_dlcr_router
